/* inc/dual_timer_pkg.sv */
// Shared constants for the dual interval and pulse timer.
// Assumes a 20 MHz reference clock and a synchronous channel strobe.
package dual_timer_pkg;

    // Timer width and power-on values
    localparam int TMR_W = 16;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] MODE_RESET = 16'h0000;

    // Channel address layout
    localparam int ADDR_PGM_BIT = 16;
    localparam int ADDR_DEV_HI = 15;
    localparam int ADDR_DEV_LO = 9;
    localparam int ADDR_SEL_BIT = 8;
    localparam int ADDR_CMD_HI = 7;

    // Command codes
    localparam logic [7:0] CMD_PREPARE = 8'h10;
    localparam logic [7:0] CMD_SET_VALUE = 8'h20;
    localparam logic [7:0] CMD_SET_MODE = 8'h22;
    localparam logic [7:0] CMD_START_PER = 8'h30;
    localparam logic [7:0] CMD_START_APER = 8'h31;
    localparam logic [7:0] CMD_STOP = 8'h32;
    localparam logic [7:0] CMD_READ_VALUE = 8'h40;
    localparam logic [7:0] CMD_DEV_RESET = 8'h7f;

    // Mode word and prepare word fields
    localparam int MODE_GATE_BIT = 15;
    localparam int MODE_EXT_BIT = 14;
    localparam int MODE_BASE_LSB = 0;
    localparam int PREP_IBIT = 0;

    // Interrupt condition codes
    localparam logic [2:0] COND_EXC = 3'h2;
    localparam logic [2:0] COND_DEV_END = 3'h3;
    localparam logic [2:0] COND_ATT = 3'h4;
    localparam logic [2:0] COND_ATT_EXC = 3'h6;
    localparam logic [2:0] COND_ATT_DE = 3'h7;

    // Command answer codes
    localparam logic [2:0] ANS_OK = 3'h7;
    localparam logic [2:0] ANS_REJECT = 3'h1;
    localparam logic [2:0] ANS_PAR_ERR = 3'h5;

    // Time bases
    localparam int CLK_PERIOD_NS = 50;
    localparam int BASE_UNIT_NS = 1000;
    localparam int CYC_PER_UNIT = BASE_UNIT_NS / CLK_PERIOD_NS;
    localparam int BASE_B_UNITS = 5;
    localparam int BASE_C_UNITS = 25;
    localparam int BASE_D_UNITS = 50;

endpackage : dual_timer_pkg

/* core/pin_sync.sv */
// Three-stage synchroniser with agreement filter for one active-low pin.
// Assumes the pin idles high (pulled up) and is asynchronous.
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Pin and result
    input wire logic i_pin_b,
    output logic o_active
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // Capture chain, idle high
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
        end else begin
            s1_reg <= i_pin_b;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Level changes once stages two and three agree
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_active <= 1'b0;
        end else if (s2_reg == s3_reg) begin
            o_active <= ~s3_reg;
        end
    end
endmodule : pin_sync

/* core/base_tick_div.sv */
// Internal time-base divider: one-cycle enables every 1, 5, 25 and 50 units.
// Assumes the reference clock rate set in the package.
`timescale 1ns/1ps
module base_tick_div
    import dual_timer_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Enables, index is the base select
    output logic [3:0] o_base_tick
);
    localparam logic [4:0] PRE_LAST = 5'(CYC_PER_UNIT - 1);
    localparam logic [5:0] UNIT_LAST = 6'(BASE_D_UNITS - 1);

    logic [4:0] pre_reg;
    logic [5:0] unit_reg;
    logic unit_tick;

    assign unit_tick = (pre_reg == PRE_LAST);

    // Cycle prescaler
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || unit_tick) begin
            pre_reg <= 5'h00;
        end else begin
            pre_reg <= pre_reg + 5'h01;
        end
    end

    // Unit counter
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            unit_reg <= 6'h00;
        end else if (unit_tick) begin
            unit_reg <= (unit_reg == UNIT_LAST) ? 6'h00 : unit_reg + 6'h01;
        end
    end

    // Enables
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_base_tick <= 4'h0;
        end else begin
            o_base_tick[0] <= unit_tick;
            o_base_tick[1] <= unit_tick && (int'(unit_reg) % BASE_B_UNITS == BASE_B_UNITS - 1);
            o_base_tick[2] <= unit_tick && (int'(unit_reg) % BASE_C_UNITS == BASE_C_UNITS - 1);
            o_base_tick[3] <= unit_tick && (unit_reg == UNIT_LAST);
        end
    end
endmodule : base_tick_div

/* core/dual_interval_pulse_timer.sv */
// Two 16-bit down-counting timers behind a direct program control channel.
// Assumes channel strobes are synchronous to i_ref_clk; timer pins are not.
// Behaviour
// - Seven address bits match; address bit 8 picks timer.
// - Odd parity per byte, generated and checked.
// - Address bit 16 gates command reception.
// - Program control only; no cycle steal, no load.
// - Four active-low pins per timer.
// - External pulse counts on inactive-to-active edge.
// - Each external pulse counted once only.
// - Gate pin ignored unless mode gate bit set.
// - Run pin from start until stop, gate, reset.
// - Gate-enable pin follows mode bit 15.
// - Mode bit 14 selects external clock.
// - Periodic load N interrupts every N+1 pulses.
// - Running timer decrements per tick, underflow interrupts.
// - Armed gate becoming active starts counting.
// - Armed gate dropping stops, clears run, attention.
// - Condition codes 2, 3, 4, 6, 7 reported.
// - Periodic mode reloads from auto-load on underflow.
// - Underflow reports device end code 3.
// - Device end while pending flags overrun exception.
// - Halt, check, device reset clear run, mode, pending.
`timescale 1ns/1ps
module dual_interval_pulse_timer
(
    // Clock and power-on reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Other resets
    input wire logic i_halt_mchk,
    input wire logic i_sys_reset,
    // Device address strap
    input wire logic [6:0] i_dev_addr,
    // Command channel
    input wire logic [16:0] i_addr_bus,
    input wire logic i_addr_gate,
    input wire logic [15:0] i_data_bus,
    input wire logic [1:0] i_data_par,
    output logic [15:0] o_data_bus,
    output logic [1:0] o_data_par,
    output logic o_data_oe,
    output logic o_addr_gate_return,
    output logic [2:0] o_cmd_code,
    output logic o_cs_req,
    // Interrupt request
    output logic o_irq_req,
    output logic o_irq_timer,
    output logic [2:0] o_irq_code,
    input wire logic i_irq_ack,
    // Timer pins, active low
    input wire logic [1:0] i_tmr_clk_b,
    input wire logic [1:0] i_tmr_gate_b,
    output logic [1:0] o_tmr_run_b,
    output logic [1:0] o_tmr_gate_en_b
);
    import dual_timer_pkg::*;

    logic [15:0] cnt_reg [2];
    logic [15:0] auto_reg [2];
    logic [15:0] mode_reg [2];
    logic [1:0] run_reg;
    logic [1:0] per_reg;
    logic [1:0] de_pend_reg;
    logic [1:0] att_pend_reg;
    logic [1:0] exc_pend_reg;
    logic [1:0] clk_act;
    logic [1:0] clk_act_d_reg;
    logic [1:0] gate_act;
    logic [1:0] gate_act_d_reg;
    logic [1:0] underflow;
    logic [1:0] gate_end;
    logic [1:0] ack_t;
    logic [1:0] pend_any;
    logic [3:0] base_tick;
    logic ibit_reg;
    logic cmd_hit;
    logic sel;
    logic [7:0] cmd;
    logic par_ok;
    logic accept;
    logic [2:0] answer;
    logic [1:0] do_load;
    logic [1:0] do_mode;
    logic [1:0] do_start;
    logic [1:0] do_stop;
    logic do_prep;
    logic do_devrst;
    logic do_read;
    logic clear_all;

    // Time base and pin synchronisers
    base_tick_div u_base_tick_div (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .o_base_tick(base_tick)
    );

    for (genvar p = 0; p < 2; p++) begin : g_sync
        pin_sync u_clk_sync (
            .i_ref_clk(i_ref_clk),
            .i_rst_b(i_rst_b),
            .i_pin_b(i_tmr_clk_b[p]),
            .o_active(clk_act[p])
        );
        pin_sync u_gate_sync (
            .i_ref_clk(i_ref_clk),
            .i_rst_b(i_rst_b),
            .i_pin_b(i_tmr_gate_b[p]),
            .o_active(gate_act[p])
        );
    end

    // Command decode
    assign cmd_hit = i_addr_gate && i_addr_bus[ADDR_PGM_BIT]
        && (i_addr_bus[ADDR_DEV_HI:ADDR_DEV_LO] == i_dev_addr);
    assign sel = i_addr_bus[ADDR_SEL_BIT];
    assign cmd = i_addr_bus[ADDR_CMD_HI:0];
    assign par_ok = (i_data_par[1] == ~^i_data_bus[15:8])
        && (i_data_par[0] == ~^i_data_bus[7:0]);
    assign clear_all = i_halt_mchk || i_sys_reset || do_devrst;
    assign o_cs_req = 1'b0;

    always_comb begin
        accept = 1'b0;
        answer = ANS_REJECT;
        do_load = 2'b00;
        do_mode = 2'b00;
        do_start = 2'b00;
        do_stop = 2'b00;
        do_prep = 1'b0;
        do_devrst = 1'b0;
        do_read = 1'b0;
        if (!cmd_hit) begin
            answer = ANS_REJECT;
        end else if ((cmd == CMD_PREPARE || cmd == CMD_SET_VALUE || cmd == CMD_SET_MODE)
            && !par_ok) begin
            answer = ANS_PAR_ERR;
        end else if (cmd == CMD_PREPARE) begin
            accept = 1'b1;
            do_prep = 1'b1;
        end else if (cmd == CMD_DEV_RESET) begin
            accept = 1'b1;
            do_devrst = 1'b1;
        end else if (cmd == CMD_SET_VALUE && !run_reg[sel]) begin
            accept = 1'b1;
            do_load[sel] = 1'b1;
        end else if (cmd == CMD_SET_MODE && !run_reg[sel]) begin
            accept = 1'b1;
            do_mode[sel] = 1'b1;
        end else if (cmd == CMD_START_PER || cmd == CMD_START_APER) begin
            accept = 1'b1;
            do_start[sel] = 1'b1;
        end else if (cmd == CMD_STOP) begin
            accept = 1'b1;
            do_stop[sel] = 1'b1;
        end else if (cmd == CMD_READ_VALUE) begin
            accept = 1'b1;
            do_read = 1'b1;
        end
        if (accept) begin
            answer = ANS_OK;
        end
    end

    // Command answer, one cycle after the strobe
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_addr_gate_return <= 1'b0;
            o_cmd_code <= 3'h0;
        end else begin
            o_addr_gate_return <= cmd_hit;
            o_cmd_code <= cmd_hit ? answer : 3'h0;
        end
    end

    // Read data with byte parity
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_data_bus <= 16'h0000;
            o_data_par <= 2'b00;
            o_data_oe <= 1'b0;
        end else begin
            o_data_oe <= do_read;
            if (do_read) begin
                o_data_bus <= cnt_reg[sel];
                o_data_par <= {~^cnt_reg[sel][15:8], ~^cnt_reg[sel][7:0]};
            end
        end
    end

    // Prepare field
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || i_sys_reset) begin
            ibit_reg <= 1'b0;
        end else if (do_prep) begin
            ibit_reg <= i_data_bus[PREP_IBIT];
        end
    end

    // Interrupt presentation, timer 0 first
    assign pend_any = de_pend_reg | att_pend_reg | exc_pend_reg;
    assign o_irq_req = ibit_reg && (pend_any != 2'b00);
    assign o_irq_timer = !pend_any[0];
    assign ack_t = {i_irq_ack && o_irq_req && o_irq_timer, i_irq_ack && o_irq_req && !o_irq_timer};

    always_comb begin
        if (att_pend_reg[o_irq_timer] && exc_pend_reg[o_irq_timer]) begin
            o_irq_code = COND_ATT_EXC;
        end else if (att_pend_reg[o_irq_timer] && de_pend_reg[o_irq_timer]) begin
            o_irq_code = COND_ATT_DE;
        end else if (att_pend_reg[o_irq_timer]) begin
            o_irq_code = COND_ATT;
        end else if (exc_pend_reg[o_irq_timer]) begin
            o_irq_code = COND_EXC;
        end else if (de_pend_reg[o_irq_timer]) begin
            o_irq_code = COND_DEV_END;
        end else begin
            o_irq_code = 3'h0;
        end
    end

    // Per-timer logic
    for (genvar t = 0; t < 2; t++) begin : g_tmr
        logic tick;
        logic clk_rise;
        logic counting;

        // Edge seen whether running or not, so a restart never recounts
        assign clk_rise = clk_act[t] && !clk_act_d_reg[t];
        assign tick = mode_reg[t][MODE_EXT_BIT] ? clk_rise
            : base_tick[mode_reg[t][MODE_BASE_LSB +: 2]];
        assign counting = run_reg[t] && !clear_all
            && (!mode_reg[t][MODE_GATE_BIT] || gate_act[t]);
        assign underflow[t] = counting && tick && (cnt_reg[t] == 16'h0000);
        assign gate_end[t] = run_reg[t] && mode_reg[t][MODE_GATE_BIT]
            && gate_act_d_reg[t] && !gate_act[t];

        always_ff @(posedge i_ref_clk) begin
            if (!i_rst_b) begin
                clk_act_d_reg[t] <= 1'b0;
                gate_act_d_reg[t] <= 1'b0;
            end else begin
                clk_act_d_reg[t] <= clk_act[t];
                gate_act_d_reg[t] <= gate_act[t];
            end
        end

        // Run state
        always_ff @(posedge i_ref_clk) begin
            if (!i_rst_b || clear_all) begin
                run_reg[t] <= 1'b0;
                per_reg[t] <= 1'b0;
            end else if (do_stop[t] || gate_end[t]) begin
                run_reg[t] <= 1'b0;
            end else if (do_start[t]) begin
                run_reg[t] <= 1'b1;
                per_reg[t] <= (cmd == CMD_START_PER);
            end
        end

        // Mode register
        always_ff @(posedge i_ref_clk) begin
            if (!i_rst_b || clear_all) begin
                mode_reg[t] <= MODE_RESET;
            end else if (do_mode[t]) begin
                mode_reg[t] <= i_data_bus;
            end
        end

        // Count and auto-load, kept through halt and system reset
        always_ff @(posedge i_ref_clk) begin
            if (!i_rst_b) begin
                cnt_reg[t] <= CNT_MAX;
                auto_reg[t] <= CNT_MAX;
            end else if (do_load[t]) begin
                cnt_reg[t] <= i_data_bus;
                auto_reg[t] <= i_data_bus;
            end else if (underflow[t] && per_reg[t]) begin
                cnt_reg[t] <= auto_reg[t];
            end else if (counting && tick) begin
                cnt_reg[t] <= cnt_reg[t] - 16'h0001;
            end
        end

        // Pending conditions, a new event wins over the acknowledge
        always_ff @(posedge i_ref_clk) begin
            if (!i_rst_b || clear_all) begin
                de_pend_reg[t] <= 1'b0;
                att_pend_reg[t] <= 1'b0;
                exc_pend_reg[t] <= 1'b0;
            end else begin
                de_pend_reg[t] <= underflow[t] || (de_pend_reg[t] && !ack_t[t]);
                att_pend_reg[t] <= gate_end[t] || (att_pend_reg[t] && !ack_t[t]);
                exc_pend_reg[t] <= (underflow[t] && de_pend_reg[t] && !ack_t[t])
                    || (exc_pend_reg[t] && !ack_t[t]);
            end
        end

        // Pins
        assign o_tmr_run_b[t] = !run_reg[t];
        assign o_tmr_gate_en_b[t] = !mode_reg[t][MODE_GATE_BIT];
        a_start_run: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
            do_start[t] && !clear_all |=> !o_tmr_run_b[t])
            else $error("run pin not active after start");
        a_gate_en_pin: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
            do_mode[t] && !clear_all && i_data_bus[MODE_GATE_BIT] |=> !o_tmr_gate_en_b[t])
            else $error("gate enable pin not following mode");
        a_periodic_reload: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
            underflow[t] && per_reg[t] |=> cnt_reg[t] == $past(auto_reg[t]))
            else $error("periodic reload missed");
        a_aper_wrap: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
            underflow[t] && !per_reg[t] |=> cnt_reg[t] == CNT_MAX)
            else $error("aperiodic underflow did not wrap");
        a_dev_end_set: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
            underflow[t] && !clear_all |=> de_pend_reg[t])
            else $error("device end not pending after underflow");
        a_overrun_set: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
            underflow[t] && de_pend_reg[t] && !ack_t[t] && !clear_all |=> exc_pend_reg[t])
            else $error("overrun not flagged");
        a_gate_drop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
            gate_end[t] && !clear_all |=> !run_reg[t] && att_pend_reg[t])
            else $error("gate drop did not stop timer");
        a_halt_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
            i_halt_mchk |=> !run_reg[t] && mode_reg[t] == MODE_RESET && !pend_any[t]
                && cnt_reg[t] == $past(cnt_reg[t]))
            else $error("halt did not clear timer state");
        a_gate_ignored: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
            run_reg[t] && !mode_reg[t][MODE_GATE_BIT] && tick && !do_load[t] && !clear_all
                && cnt_reg[t] != 16'h0000 |=> cnt_reg[t] == $past(cnt_reg[t]) - 16'h0001)
            else $error("count held while gate disarmed");
    end
    a_pgm_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        i_addr_gate && !i_addr_bus[ADDR_PGM_BIT] |=> !o_addr_gate_return)
        else $error("answered without address bit 16");
    a_read_parity: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        o_data_oe |-> (^{o_data_par[1], o_data_bus[15:8]}) && (^{o_data_par[0], o_data_bus[7:0]}))
        else $error("read data parity not odd");
endmodule : dual_interval_pulse_timer

/* tb/ext_circuit_model.sv */
// Customer circuitry model: drives the clock and gate pins of both timers.
// Assumes pins idle high through pull-ups and change after the clock edge.
`timescale 1ns/1ps
module ext_circuit_model (
    // Clock and observed run state
    input wire logic i_ref_clk,
    input wire logic [1:0] i_run_b,
    // Customer pins, active low
    output logic [1:0] o_clk_b,
    output logic [1:0] o_gate_b
);
    initial begin
        o_clk_b = 2'b11;
        o_gate_b = 2'b11;
    end

    // One active-low pulse, then idle at the pull-up level
    task automatic pulse(input int idx, input int len);
        @(posedge i_ref_clk);
        #2 o_clk_b[idx] = 1'b0;
        repeat (len) @(posedge i_ref_clk);
        #2 o_clk_b[idx] = 1'b1;
        repeat (8) @(posedge i_ref_clk);
    endtask : pulse

    // Gate only goes active once the run state is seen
    task automatic gate(input int idx, input logic on);
        @(posedge i_ref_clk);
        if (!on || i_run_b[idx] === 1'b0) begin
            #2 o_gate_b[idx] = ~on;
        end
    endtask : gate
endmodule : ext_circuit_model

/* tb/tb.sv */
// Self-checking bench for the dual timer: channel commands and pin traffic.
// Assumes the customer circuitry model and the design package.
`timescale 1ns/1ps
module tb;
    import dual_timer_pkg::*;
    localparam logic [6:0] DEV = 7'h2a;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic halt = 1'b0;
    logic sreset = 1'b0;
    logic agate = 1'b0;
    logic ack = 1'b0;
    logic [16:0] abus = 17'h00000;
    logic [15:0] dbus = 16'h0000;
    logic [1:0] dpar = 2'b11;
    logic [15:0] o_data;
    logic [1:0] o_par;
    logic oe, ret, cs, irq, irq_t;
    logic [2:0] dcc, icc;
    logic [1:0] clk_b, gate_b, run_b, gen_b;
    logic [15:0] rd, rd2;
    int bad_count = 0;
    int checks_done = 0;
    int span;

    always #25 clk = ~clk;

    dual_interval_pulse_timer uut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_halt_mchk(halt),
        .i_sys_reset(sreset), .i_dev_addr(DEV), .i_addr_bus(abus), .i_addr_gate(agate),
        .i_data_bus(dbus), .i_data_par(dpar), .o_data_bus(o_data), .o_data_par(o_par),
        .o_data_oe(oe), .o_addr_gate_return(ret), .o_cmd_code(dcc), .o_cs_req(cs),
        .o_irq_req(irq), .o_irq_timer(irq_t), .o_irq_code(icc), .i_irq_ack(ack),
        .i_tmr_clk_b(clk_b), .i_tmr_gate_b(gate_b), .o_tmr_run_b(run_b),
        .o_tmr_gate_en_b(gen_b));
    ext_circuit_model ext (.i_ref_clk(clk), .i_run_b(run_b), .o_clk_b(clk_b), .o_gate_b(gate_b));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_code(input logic [2:0] got, input logic [2:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_code

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step

    function automatic logic [16:0] adr(input logic sel, input logic [7:0] code);
        return {1'b1, DEV, sel, code};
    endfunction : adr

    // One strobe; answer is looked at in the single cycle after it is taken
    task automatic cmd(input logic [16:0] a, input logic [15:0] d, input logic perr,
                       input logic hit, input logic [2:0] cc);
        step(1);
        abus = a;
        dbus = d;
        dpar = {~^d[15:8], ~^d[7:0] ^ perr};
        agate = 1'b1;
        step(1);
        agate = 1'b0;
        chk_bit(ret, hit);
        if (hit) begin
            chk_code(dcc, cc);
        end
        if (hit && a[7:0] == CMD_READ_VALUE) begin
            rd = o_data;
            chk_bit(oe, 1'b1);
            chk_word({14'h0, o_par}, {14'h0, ~^o_data[15:8], ~^o_data[7:0]});
        end
    endtask : cmd

    task automatic rd_tmr(input logic sel);
        cmd(adr(sel, CMD_READ_VALUE), 16'h0000, 1'b0, 1'b1, ANS_OK);
    endtask : rd_tmr

    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < lim) begin
            step(1);
            n++;
        end
        if (irq !== 1'b1) begin
            bad_count++;
            complete_run();
        end
    endtask : wait_irq

    task automatic do_ack();
        step(1);
        ack = 1'b1;
        step(1);
        ack = 1'b0;
        step(1);
        chk_bit(irq, 1'b0);
    endtask : do_ack

    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        complete_run();
    end

    initial begin
        step(16);
        rst_b = 1'b1;
        step(4);
        chk_bit(cs, 1'b0);
        chk_word({12'h0, run_b, gen_b}, 16'h000f);
        rd_tmr(1'b0);
        chk_word(rd, CNT_MAX);
        cmd({1'b1, ~DEV, 1'b0, CMD_READ_VALUE}, 16'h0, 1'b0, 1'b0, ANS_OK);
        cmd({1'b0, DEV, 1'b0, CMD_READ_VALUE}, 16'h0, 1'b0, 1'b0, ANS_OK);
        cmd(adr(1'b0, 8'h55), 16'h0, 1'b0, 1'b1, ANS_REJECT);
        cmd(adr(1'b0, CMD_SET_VALUE), 16'h1234, 1'b1, 1'b1, ANS_PAR_ERR);
        rd_tmr(1'b0);
        chk_word(rd, CNT_MAX);
        cmd(adr(1'b1, CMD_PREPARE), 16'h0001, 1'b0, 1'b1, ANS_OK);
        // Timer 1 counts customer clock pulses, periodic, loaded with 2
        cmd(adr(1'b1, CMD_SET_VALUE), 16'h0002, 1'b0, 1'b1, ANS_OK);
        cmd(adr(1'b1, CMD_SET_MODE), 16'h4000, 1'b0, 1'b1, ANS_OK);
        step(1);
        chk_bit(gen_b[1], 1'b1);
        cmd(adr(1'b1, CMD_START_PER), 16'h0, 1'b0, 1'b1, ANS_OK);
        step(1);
        chk_bit(run_b[1], 1'b0);
        cmd(adr(1'b1, CMD_SET_VALUE), 16'h0005, 1'b0, 1'b1, ANS_REJECT);
        fork
            ext.pulse(1, 40);
            begin
                repeat (12) @(posedge clk);
                cmd(adr(1'b1, CMD_STOP), 16'h0, 1'b0, 1'b1, ANS_OK);
                step(1);
                chk_bit(run_b[1], 1'b1);
                cmd(adr(1'b1, CMD_START_PER), 16'h0, 1'b0, 1'b1, ANS_OK);
            end
        join
        rd_tmr(1'b1);
        chk_word(rd, 16'h0001);
        ext.pulse(1, 4);
        rd_tmr(1'b1);
        chk_word(rd, 16'h0000);
        chk_bit(irq, 1'b0);
        ext.pulse(1, 4);
        wait_irq(20);
        chk_bit(irq_t, 1'b1);
        chk_code(icc, COND_DEV_END);
        rd_tmr(1'b1);
        chk_word(rd, 16'h0002);
        repeat (3) ext.pulse(1, 4);
        chk_code(icc, COND_EXC);
        do_ack();
        cmd(adr(1'b1, CMD_STOP), 16'h0, 1'b0, 1'b1, ANS_OK);
        // Timer 0 on the 1 us base, gate not armed: counts regardless of gate
        cmd(adr(1'b0, CMD_SET_VALUE), 16'h03e8, 1'b0, 1'b1, ANS_OK);
        cmd(adr(1'b0, CMD_SET_MODE), 16'h0000, 1'b0, 1'b1, ANS_OK);
        cmd(adr(1'b0, CMD_START_APER), 16'h0, 1'b0, 1'b1, ANS_OK);
        step(100);
        rd_tmr(1'b0);
        chk_bit(rd < 16'h03e8, 1'b1);
        cmd(adr(1'b0, CMD_STOP), 16'h0, 1'b0, 1'b1, ANS_OK);
        cmd(adr(1'b0, CMD_SET_VALUE), 16'h03e8, 1'b0, 1'b1, ANS_OK);
        cmd(adr(1'b0, CMD_SET_MODE), 16'h8000, 1'b0, 1'b1, ANS_OK);
        step(1);
        chk_bit(gen_b[0], 1'b0);
        cmd(adr(1'b0, CMD_START_APER), 16'h0, 1'b0, 1'b1, ANS_OK);
        step(100);
        rd_tmr(1'b0);
        chk_word(rd, 16'h03e8);
        ext.gate(0, 1'b1);
        step(200);
        ext.gate(0, 1'b0);
        step(8);
        chk_bit(run_b[0], 1'b1);
        wait_irq(20);
        chk_bit(irq_t, 1'b0);
        chk_code(icc, COND_ATT);
        rd_tmr(1'b0);
        chk_bit(rd >= 16'h03dc && rd <= 16'h03e0, 1'b1);
        do_ack();
        // Zero load underflows every tick: overrun, then gate drop
        cmd(adr(1'b0, CMD_SET_VALUE), 16'h0000, 1'b0, 1'b1, ANS_OK);
        cmd(adr(1'b0, CMD_START_PER), 16'h0, 1'b0, 1'b1, ANS_OK);
        ext.gate(0, 1'b1);
        step(100);
        ext.gate(0, 1'b0);
        step(8);
        chk_code(icc, COND_ATT_EXC);
        do_ack();
        // Halt, device reset and system reset all stop a running timer
        cmd(adr(1'b0, CMD_START_APER), 16'h0, 1'b0, 1'b1, ANS_OK);
        halt = 1'b1;
        step(1);
        halt = 1'b0;
        step(1);
        chk_word({12'h0, run_b, gen_b}, 16'h000f);
        rd_tmr(1'b0);
        rd2 = rd;
        step(40);
        rd_tmr(1'b0);
        chk_word(rd, rd2);
        cmd(adr(1'b0, CMD_START_APER), 16'h0, 1'b0, 1'b1, ANS_OK);
        cmd(adr(1'b0, CMD_DEV_RESET), 16'h0, 1'b0, 1'b1, ANS_OK);
        step(1);
        chk_bit(run_b[0], 1'b1);
        cmd(adr(1'b0, CMD_START_APER), 16'h0, 1'b0, 1'b1, ANS_OK);
        sreset = 1'b1;
        step(1);
        sreset = 1'b0;
        step(1);
        chk_bit(run_b[0], 1'b1);
        // Slower internal bases, 2000 cycles each
        for (int b = 1; b < 4; b++) begin
            cmd(adr(1'b0, CMD_SET_VALUE), 16'h03e8, 1'b0, 1'b1, ANS_OK);
            cmd(adr(1'b0, CMD_SET_MODE), 16'(b), 1'b0, 1'b1, ANS_OK);
            cmd(adr(1'b0, CMD_START_APER), 16'h0, 1'b0, 1'b1, ANS_OK);
            step(2000);
            rd_tmr(1'b0);
            span = (b == 1) ? BASE_B_UNITS : (b == 2) ? BASE_C_UNITS : BASE_D_UNITS;
            span = 2000 / (CYC_PER_UNIT * span);
            chk_bit(rd + 16'(span) >= 16'h03e7 && rd + 16'(span) <= 16'h03e9, 1'b1);
            cmd(adr(1'b0, CMD_STOP), 16'h0, 1'b0, 1'b1, ANS_OK);
        end
        complete_run();
    end
endmodule : tb
